//--- pcm_framer_model.sv
// Purpose: framer model, shift clock, frame pulse and serial input data
// Assumes: 200 ns shift clock, standing still between runs
// Notes: pulse polarity gives the format; output bits read in each cell's second half
`default_nettype none
module pcm_framer_model (
    output logic shift_clk,
    output logic frame_pulse,
    output logic recv_in,
    output logic send_in,
    output logic [3:0] ch,
    output logic [7:0] got_s,
    output logic [7:0] got_r,
    output logic got_stb,
    input wire logic send_out,
    input wire logic recv_out,
    input wire logic gci,
    input wire logic run,
    input wire logic [7:0] byte_r,
    input wire logic [7:0] byte_s
);
    timeunit 1ns;
    timeprecision 1ps;
    int b;
    initial begin
        {shift_clk, recv_in, send_in, got_stb, ch, got_s, got_r} = '0;
        frame_pulse = 1'b1;
        forever begin
            while (run !== 1'b1) begin
                frame_pulse = !gci;
                #10;
            end
            for (b = 0; b < 128; b++) begin
                shift_clk = 1'b0;
                frame_pulse = !gci;
                ch = b[6:3];
                #1;
                recv_in = byte_r[7 - b[2:0]];
                send_in = byte_s[7 - b[2:0]];
                #99 shift_clk = 1'b1;
                #100 shift_clk = 1'b0;
                // pulse only when another frame follows, so no stray frame start
                if (b == 127 && run === 1'b1) frame_pulse = gci;
                #100 shift_clk = 1'b1;
                got_s = {got_s[6:0], send_out};
                got_r = {got_r[6:0], recv_out};
                if (b[2:0] == 3'h7) got_stb = !got_stb;
                #100;
            end
            // released lines must not keep the last bit
            recv_in = !recv_in;
            send_in = !send_in;
        end
    end
endmodule
`default_nettype wire

//--- pcm_pkg.sv
// Purpose: constants for the serial tdm port
// Assumes: 40 MHz core clock, 4.096 MHz shift clock
// Notes: frame length derives from channel count and bits per channel; no count uses the clock rate
`default_nettype none
package pcm_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int SHIFT_CLOCK_HZ = 4096000;
    localparam int CHANNELS = 16;
    localparam int CHANNEL_BITS = 8;
    localparam int FRAME_BITS = CHANNELS * CHANNEL_BITS;
    localparam int BIT_CNT_W = 7;
    // longest frame pulse, in shift clock falls, still taken as a pulse
    localparam logic [2:0] PULSE_MAX_FALLS = 3'h3;
    localparam int CTRL_DRIVE_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    typedef enum logic [1:0] {
        FMT_NONE = 2'b00,
        FMT_BUS = 2'b01,
        FMT_GCI = 2'b10
    } pcm_format_type;
endpackage
`default_nettype wire

//--- pcm_sync.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: input asynchronous to CLK
// Notes: first stage read only by second stage
`default_nettype none
module pcm_sync (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic d,
    output logic q
);
    logic meta;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

//--- pcm_tdm_port.sv
// Purpose: serial pcm tdm port, two inputs and two outputs
// Assumes: shift clock and frame pulse sampled by CLK
// Notes: frame format found from the pulse polarity, pulse told from idle by its width in shift clocks
// Notes on behaviour
// R1 - inputs take 16 channel 2.048 Mb/s stream
// R2 - outputs send 16 channel 2.048 Mb/s stream
// R3 - receive in/send out port one, rest two
// R4 - 4.096 MHz shift clock moves all streams
// R5 - frame format detected automatically, no setting
// R6 - outputs drive when pin and bit6 high
// R7 - otherwise both outputs high impedance
// R8 - master clock asynchronous, synchronised crossing
// R9 - rate select chosen by outside party
// R10 - reset gives standby, control defaults restored
// R11 - two shift clocks per data bit
`default_nettype none
module pcm_tdm_port
    import pcm_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SHIFT_CLOCK_IN,
    input wire logic FRAME_PULSE_IN,
    input wire logic OUTPUT_DRIVE_ENABLE,
    input wire logic [7:0] CONTROL,
    input wire logic CONTROL_LOAD,
    input wire logic RECV_IN,
    input wire logic SEND_IN,
    output logic SEND_OUT,
    output logic SEND_OUT_OE,
    output logic RECV_OUT,
    output logic RECV_OUT_OE,
    output logic [7:0] RECV_IN_BYTE,
    output logic [7:0] SEND_IN_BYTE,
    output logic [3:0] IN_CHANNEL,
    output logic IN_VALID,
    input wire logic [7:0] SEND_OUT_BYTE,
    input wire logic [7:0] RECV_OUT_BYTE,
    output logic [3:0] OUT_CHANNEL,
    output logic OUT_LOAD,
    output logic [1:0] FRAME_FORMAT,
    output logic STANDBY
);
    import pcm_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic clk_s, fp_s, drive_en_s, rin_s, sin_s;
    logic [4:0] raw;
    logic [4:0] synced;
    assign raw = {SHIFT_CLOCK_IN, FRAME_PULSE_IN, OUTPUT_DRIVE_ENABLE, RECV_IN, SEND_IN};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            pcm_sync u_sync (
                .CLK(CLK),
                .RESET_N(RESET_N),
                .d(raw[gi]),
                .q(synced[gi])
            ); // R8
        end
    endgenerate
    assign {clk_s, fp_s, drive_en_s, rin_s, sin_s} = synced;

    // ----------------------------------------------------------------
    // shift clock edges
    // ----------------------------------------------------------------
    logic clk_d;
    logic rise, fall;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clk_d <= 1'b0;
        end else begin
            clk_d <= clk_s;
        end
    end
    assign rise = clk_s & ~clk_d; // R4
    assign fall = ~clk_s & clk_d;

    // ----------------------------------------------------------------
    // frame format detection
    // ----------------------------------------------------------------
    // bus format pulse is low, gci pulse is high; both span at most one bit
    // polarity alone cannot tell pulse from idle, so the length of each level is counted:
    // idle lasts a whole frame, the pulse only a few falls
    logic fp_d;
    logic [2:0] fp_len;
    logic pulse_end;
    pcm_format_type fmt;
    logic frame_start;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fp_d <= 1'b0;
            fp_len <= 3'h0;
        end else if (fall) begin
            fp_d <= fp_s;
            if (fp_s != fp_d) begin
                fp_len <= 3'h1;
            end else if (fp_len != 3'h7) begin
                fp_len <= fp_len + 3'h1;
            end
        end
    end
    // length zero means no level seen yet, so leaving reset cannot fake a pulse
    assign pulse_end = fall && (fp_s != fp_d) && (fp_len != 3'h0) &&
        (fp_len <= PULSE_MAX_FALLS); // R5
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fmt <= FMT_NONE;
        end else if (pulse_end) begin
            if (fp_s) begin
                fmt <= FMT_BUS; // R5
            end else begin
                fmt <= FMT_GCI; // R5
            end
        end
    end
    // frame aligns at the trailing edge of the pulse, either polarity
    assign frame_start = pulse_end; // R5

    // ----------------------------------------------------------------
    // bit timing
    // ----------------------------------------------------------------
    logic half;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic locked;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            half <= 1'b0;
            bit_cnt <= '0;
            locked <= 1'b0;
        end else if (frame_start) begin
            half <= 1'b0;
            bit_cnt <= '0;
            locked <= 1'b1;
        end else if (fall) begin
            half <= ~half; // R11
            if (half) begin
                bit_cnt <= bit_cnt + 7'h01; // R1
            end
        end
    end

    // ----------------------------------------------------------------
    // receive shifters, one per input port
    // ----------------------------------------------------------------
    logic [7:0] rsh, ssh;
    logic sample;
    assign sample = rise && half && locked; // R11
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rsh <= 8'h00;
            ssh <= 8'h00;
            RECV_IN_BYTE <= 8'h00;
            SEND_IN_BYTE <= 8'h00;
            IN_CHANNEL <= 4'h0;
            IN_VALID <= 1'b0;
        end else begin
            IN_VALID <= 1'b0;
            if (sample) begin
                rsh <= {rsh[6:0], rin_s}; // R3
                ssh <= {ssh[6:0], sin_s}; // R3
                if (bit_cnt[2:0] == 3'h7) begin
                    RECV_IN_BYTE <= {rsh[6:0], rin_s}; // R1
                    SEND_IN_BYTE <= {ssh[6:0], sin_s};
                    IN_CHANNEL <= bit_cnt[6:3];
                    IN_VALID <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit shifters
    // ----------------------------------------------------------------
    logic [7:0] tsh_s, tsh_r;
    logic launch;
    assign launch = fall && !half && locked;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tsh_s <= 8'h00;
            tsh_r <= 8'h00;
            SEND_OUT <= 1'b1;
            RECV_OUT <= 1'b1;
            OUT_CHANNEL <= 4'h0;
            OUT_LOAD <= 1'b0;
        end else begin
            OUT_LOAD <= 1'b0;
            if (launch) begin
                if (bit_cnt[2:0] == 3'h0) begin
                    SEND_OUT <= SEND_OUT_BYTE[7]; // R2
                    RECV_OUT <= RECV_OUT_BYTE[7]; // R3
                    tsh_s <= {SEND_OUT_BYTE[6:0], 1'b0};
                    tsh_r <= {RECV_OUT_BYTE[6:0], 1'b0};
                    OUT_CHANNEL <= bit_cnt[6:3];
                    OUT_LOAD <= 1'b1;
                end else begin
                    SEND_OUT <= tsh_s[7]; // R2
                    RECV_OUT <= tsh_r[7];
                    tsh_s <= {tsh_s[6:0], 1'b0};
                    tsh_r <= {tsh_r[6:0], 1'b0};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // control and drive enable
    // ----------------------------------------------------------------
    logic [7:0] ctrl;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl <= CTRL_RESET; // R10
        end else if (CONTROL_LOAD) begin
            ctrl <= CONTROL;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SEND_OUT_OE <= 1'b0;
            RECV_OUT_OE <= 1'b0;
        end else begin
            SEND_OUT_OE <= drive_en_s & ctrl[CTRL_DRIVE_BIT]; // R6 R7
            RECV_OUT_OE <= drive_en_s & ctrl[CTRL_DRIVE_BIT]; // R6 R7
        end
    end
    assign FRAME_FORMAT = fmt;
    // standby drops one edge after reset release
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            STANDBY <= 1'b1; // R10
        end else begin
            STANDBY <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_drive_and: assert property (@(posedge CLK) disable iff (!RESET_N)
        SEND_OUT_OE == ($past(drive_en_s) & $past(ctrl[CTRL_DRIVE_BIT])))
        else $error("send drive not and of pin and bit"); // R6
    chk_drive_off: assert property (@(posedge CLK) disable iff (!RESET_N)
        !$past(ctrl[CTRL_DRIVE_BIT]) |-> !SEND_OUT_OE && !RECV_OUT_OE)
        else $error("output driven while disabled"); // R7
    chk_frame_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        frame_start |=> bit_cnt == 7'h00 && !half && locked)
        else $error("frame start did not clear counter"); // R5
    chk_half_bit: assert property (@(posedge CLK) disable iff (!RESET_N)
        fall && !frame_start && half |=> bit_cnt == $past(bit_cnt) + 7'h01)
        else $error("bit counter not advanced each two clocks"); // R11
    chk_hold_bit: assert property (@(posedge CLK) disable iff (!RESET_N)
        fall && !frame_start && !half |=> bit_cnt == $past(bit_cnt))
        else $error("bit counter moved mid bit"); // R11
    chk_byte_out: assert property (@(posedge CLK) disable iff (!RESET_N)
        sample && bit_cnt[2:0] == 3'h7 |=> IN_VALID && RECV_IN_BYTE[0] == $past(rin_s))
        else $error("byte not delivered"); // R1
    chk_send_load: assert property (@(posedge CLK) disable iff (!RESET_N)
        launch && bit_cnt[2:0] == 3'h0 |=> OUT_LOAD && SEND_OUT == $past(SEND_OUT_BYTE[7]))
        else $error("send byte not launched"); // R2
    chk_port_pair: assert property (@(posedge CLK) disable iff (!RESET_N)
        launch && bit_cnt[2:0] == 3'h0 |=> RECV_OUT == $past(RECV_OUT_BYTE[7]))
        else $error("receive out not paired"); // R3
    chk_edge_rise: assert property (@(posedge CLK) disable iff (!RESET_N)
        rise |-> $past(clk_s) == 1'b0)
        else $error("rise without low before"); // R4
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the tdm port
// Assumes: framer model supplies shift clock and frame pulse
// Notes: byte tables are the reference model of all four streams
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pcm_pkg::*;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic drive_pin = 1'b1;
    logic ld = 1'b0;
    logic [7:0] ctl = 8'h40;
    logic [7:0] sob = 8'h00;
    logic [7:0] rob = 8'h00;
    logic gci = 1'b0;
    logic run = 1'b0;
    logic chk = 1'b0;
    logic sck, fp, rin, sin, so, so_oe, ro, ro_oe, iv, ol, stb, gstb;
    logic [7:0] rib, sib, gs, gr;
    logic [3:0] ich, och, pch, last_ch;
    logic [1:0] fmt;
    logic [7:0] tr[16], ts[16], tso[16], tro[16];
    wire logic so_w;
    wire logic ro_w;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    assign so_w = so_oe ? so : 1'bz;
    assign ro_w = ro_oe ? ro : 1'bz;
    always #12.5 CLK = ~CLK;
    pcm_tdm_port DUT (.CLK(CLK), .RESET_N(RESET_N), .SHIFT_CLOCK_IN(sck), .FRAME_PULSE_IN(fp),
        .OUTPUT_DRIVE_ENABLE(drive_pin), .CONTROL(ctl), .CONTROL_LOAD(ld), .RECV_IN(rin),
        .SEND_IN(sin), .SEND_OUT(so), .SEND_OUT_OE(so_oe), .RECV_OUT(ro), .RECV_OUT_OE(ro_oe),
        .RECV_IN_BYTE(rib), .SEND_IN_BYTE(sib), .IN_CHANNEL(ich), .IN_VALID(iv),
        .SEND_OUT_BYTE(sob), .RECV_OUT_BYTE(rob), .OUT_CHANNEL(och), .OUT_LOAD(ol),
        .FRAME_FORMAT(fmt), .STANDBY(stb));
    pcm_framer_model far_end (.shift_clk(sck), .frame_pulse(fp), .recv_in(rin), .send_in(sin),
        .ch(pch), .got_s(gs), .got_r(gr), .got_stb(gstb), .send_out(so_w), .recv_out(ro_w),
        .gci(gci), .run(run), .byte_r(tr[pch]), .byte_s(ts[pch]));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic load(input logic [7:0] v);
        @(negedge CLK);
        ctl <= v;
        ld <= 1'b1;
        @(negedge CLK);
        ld <= 1'b0;
    endtask
    task automatic oe_check(input logic e);
        repeat (10) @(negedge CLK);
        check("send_out_oe", {7'h0, e}, {7'h0, so_oe});
        check("recv_out_oe", {7'h0, e}, {7'h0, ro_oe});
    endtask
    // arm mid-frame, well clear of the channel 7 byte strobe
    task automatic arm();
        wait (pch !== 4'h8);
        wait (pch === 4'h8);
        #200;
        last_ch = 4'h7;
        chk = 1'b1;
    endtask
    always @(negedge CLK) begin
        sob <= tso[pch];
        rob <= tro[pch];
    end
    // outputs are looked at mid cycle, away from the edge that launches them
    always @(negedge CLK) begin
        if (chk && ol === 1'b1) begin
            check("out_channel", {4'h0, pch}, {4'h0, och});
        end
        if (chk && iv === 1'b1) begin
            check("recv_in_byte", tr[ich], rib);
            check("send_in_byte", ts[ich], sib);
            check("in_channel", {4'h0, last_ch + 4'h1}, {4'h0, ich});
            last_ch = ich;
        end
        cyc++;
        if (cyc > 40000) begin
            error_cnt++;
            give_verdict();
        end
    end
    always @(gstb) begin
        if (chk) begin
            check("send_out", tso[pch], gs);
            check("recv_out", tro[pch], gr);
        end
    end
    initial begin
        void'($urandom(32'h05f71199));
        for (int i = 0; i < 16; i++) begin
            {tr[i], ts[i], tso[i], tro[i]} = $urandom;
        end
        repeat (12) @(negedge CLK);
        check("standby", 8'h01, {7'h0, stb});
        check("format", 8'h00, {6'h0, fmt});
        check("oe", 8'h00, {7'h0, so_oe | ro_oe});
        RESET_N <= 1'b1;
        repeat (2) @(negedge CLK);
        check("standby", 8'h00, {7'h0, stb});
        run = 1'b1;
        // the port locks only at the pulse that ends the model's first frame
        wait (pch === 4'hf);
        wait (pch === 4'h0);
        arm();
        repeat (4096) @(negedge CLK);
        check("format", {6'h0, FMT_BUS}, {6'h0, fmt});
        chk = 1'b0;
        drive_pin <= 1'b0;
        oe_check(1'b0);
        drive_pin <= 1'b1;
        load(8'($urandom) & 8'hbf);
        oe_check(1'b0);
        load(8'($urandom) | 8'h40);
        oe_check(1'b1);
        run = 1'b0;
        repeat (4200) @(posedge CLK);
        gci = 1'b1;
        run = 1'b1;
        repeat (2048) @(posedge CLK);
        arm();
        repeat (2048) @(negedge CLK);
        check("format", {6'h0, FMT_GCI}, {6'h0, fmt});
        chk = 1'b0;
        load(8'h00);
        @(negedge CLK);
        RESET_N <= 1'b0;
        repeat (3) @(negedge CLK);
        check("standby", 8'h01, {7'h0, stb});
        check("format", 8'h00, {6'h0, fmt});
        RESET_N <= 1'b1;
        oe_check(1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
